// ===== hdl/sobc_top.sv
/*
  Option control and bit rate registers of the SPI unit, with pin routing,
  clock stop in wait, length change abort and the master baud tick.
  Assumes all inputs are synchronous to CLK and that the rest of the unit
  supplies role, select enable, match flag, serial data and wait state.
*/
`default_nettype none

// What this block does
// - The match interrupt request is raised while the match flag is set and its enable is 1.
// - The length bit picks 8-bit (0) or 16-bit (1) words for shifter, match and buffers.
// - In master mode a change of the length bit aborts, idles and clears status.
// - In slave mode the fault enable does nothing and the select pin is the select input.
// - In master mode fault enable 0 frees the select pin, 1 makes it fault input or output.
// - In single-wire mode the shared pin is driven when the wire output enable is 1.
// - With separate pins the wire output enable affects no pin.
// - In single-wire mode a master shares its out pin (MOSI) and a slave its out pin (MISO).
// - With wait stop set the SPI clocks halt while the processor waits.
// - The pin layout bit selects separate pins (0) or single-wire operation (1).
// - The bit rate register is always accessible and only steers the rate in master mode.
// - The prescaler divides the bus clock by its field value plus one.
// - The rate divider divides the prescaler output by two to the field value plus one.
// - The prescaler feeds the rate divider, so the rate is bus clock over both divisors.
// - With fault enabled in master, select output enable 0 is fault input, 1 drives select.
module sobc_top (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic [2:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [7:0]            RDATA,
  input  wire logic                  MASTER_SELECT,
  input  wire logic                  SELECT_OUTPUT_ENABLE,
  input  wire logic                  RECEIVE_MATCH_FLAG,
  input  wire logic                  CPU_WAIT,
  input  wire logic                  SER_OUT,
  input  wire logic                  SEL_DRIVE_N,
  input  wire sobc_pkg::sobc_pin_in_t PIN_IN,
  output sobc_pkg::sobc_pins_t       PIN_DRIVE,
  output logic                       SER_IN,
  output logic                       SLAVE_SEL_N,
  output logic                       FAULT_IN_N,
  output logic                       MATCH_IRQ,
  output logic                       WORD_16,
  output logic                       ABORT_IDLE,
  output logic                       CLK_RUN,
  output logic                       BAUD_TICK
);

  sobc_pkg::sobc_opt_t  opt_reg;
  logic [7:0]           rate_reg;
  logic [7:0]           rdata_reg;
  sobc_pkg::sobc_pins_t pins_reg;
  sobc_pkg::sobc_pins_t pins_next;
  logic                 ser_in_reg;
  logic                 ser_in_next;
  logic                 sel_n_reg;
  logic                 fault_n_reg;
  logic                 irq_reg;
  logic                 abort_reg;
  logic                 tick_reg;

  logic                                   opt_wr;
  logic                                   rate_wr;
  logic [7:0]                             opt_wdata;
  logic [sobc_pkg::FIELD_W-1:0]           prescale_field;
  logic [sobc_pkg::FIELD_W-1:0]           rate_divide_field;
  logic [sobc_pkg::PRESCALE_CNT_W-1:0]    pre_div_m1;
  logic [sobc_pkg::RATE_CNT_W-1:0]        rate_div_m1;
  logic                                   run;
  logic                                   div_en;
  logic                                   div_clear;
  logic                                   pre_tick;
  logic                                   rate_tick;
  logic                                   fault_mode;

  assign opt_wr    = WR && (ADDR == sobc_pkg::OPT_OFFSET);
  assign rate_wr   = WR && (ADDR == sobc_pkg::RATE_OFFSET);
  assign opt_wdata = WDATA & sobc_pkg::OPT_WRITE_MASK;

  // Register writes; both registers accept any access at any time
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      opt_reg <= sobc_pkg::OPT_RESET;
    end else if (opt_wr) begin
      opt_reg <= opt_wdata;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rate_reg <= sobc_pkg::RATE_RESET;
    end else if (rate_wr) begin
      rate_reg <= WDATA & sobc_pkg::RATE_WRITE_MASK;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
    end else if (RD && (ADDR == sobc_pkg::OPT_OFFSET)) begin
      rdata_reg <= opt_reg;
    end else if (RD && (ADDR == sobc_pkg::RATE_OFFSET)) begin
      rdata_reg <= rate_reg;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign RDATA = rdata_reg;

  // Match interrupt request
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= opt_reg.match_irq_enable && RECEIVE_MATCH_FLAG;
    end
  end

  assign MATCH_IRQ = irq_reg;
  assign WORD_16   = opt_reg.word_length_select;

  // Length change in master: one-cycle abort toward shifter and status
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= opt_wr && MASTER_SELECT &&
                   (opt_wdata[sobc_pkg::WORD_LEN_POS] != opt_reg.word_length_select);
    end
  end

  assign ABORT_IDLE = abort_reg;

  // Pin routing, one cycle behind the configuration
  always_comb begin
    pins_next   = '0;
    ser_in_next = 1'b0;
    if (MASTER_SELECT) begin
      pins_next.mosi_out   = SER_OUT;
      pins_next.mosi_owned = 1'b1;
      if (opt_reg.pin_layout_select) begin
        pins_next.mosi_oe    = opt_reg.single_wire_output_enable;
        pins_next.miso_owned = 1'b0;
        ser_in_next          = PIN_IN.mosi_in;
      end else begin
        pins_next.mosi_oe    = 1'b1;
        pins_next.miso_owned = 1'b1;
        ser_in_next          = PIN_IN.miso_in;
      end
      if (opt_reg.fault_detect_enable) begin
        pins_next.ss_owned = 1'b1;
        pins_next.ss_oe    = SELECT_OUTPUT_ENABLE;
        pins_next.ss_out   = SELECT_OUTPUT_ENABLE && SEL_DRIVE_N;
      end
    end else begin
      pins_next.miso_out   = SER_OUT;
      pins_next.miso_owned = 1'b1;
      pins_next.ss_owned   = 1'b1;
      if (opt_reg.pin_layout_select) begin
        pins_next.miso_oe    = opt_reg.single_wire_output_enable;
        pins_next.mosi_owned = 1'b0;
        ser_in_next          = PIN_IN.miso_in;
      end else begin
        pins_next.miso_oe    = 1'b1;
        pins_next.mosi_owned = 1'b1;
        ser_in_next          = PIN_IN.mosi_in;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pins_reg   <= '0;
      ser_in_reg <= 1'b0;
    end else begin
      pins_reg   <= pins_next;
      ser_in_reg <= ser_in_next;
    end
  end

  assign PIN_DRIVE = pins_reg;
  assign SER_IN    = ser_in_reg;

  // Select pin meaning toward the rest of the unit; idle level is high
  assign fault_mode = MASTER_SELECT && opt_reg.fault_detect_enable && !SELECT_OUTPUT_ENABLE;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_n_reg   <= 1'b1;
      fault_n_reg <= 1'b1;
    end else begin
      sel_n_reg   <= MASTER_SELECT ? 1'b1 : PIN_IN.ss_in;
      fault_n_reg <= fault_mode ? PIN_IN.ss_in : 1'b1;
    end
  end

  assign SLAVE_SEL_N = sel_n_reg;
  assign FAULT_IN_N  = fault_n_reg;

  // Clock stop in wait; exported as the gate enable for the whole unit
  assign run     = !(opt_reg.wait_clock_stop && CPU_WAIT);
  assign CLK_RUN = run;

  // Baud chain: prescaler enables the rate divider
  assign prescale_field    = rate_reg[sobc_pkg::PRESCALE_LSB +: sobc_pkg::FIELD_W];
  assign rate_divide_field = rate_reg[sobc_pkg::RATE_LSB +: sobc_pkg::FIELD_W];
  assign pre_div_m1        = prescale_field;
  assign rate_div_m1       = 8'((9'h002 << rate_divide_field) - 9'h001);
  assign div_en            = run && MASTER_SELECT;
  // Restart on a new setting so the first period is whole
  assign div_clear         = rate_wr || !MASTER_SELECT;

  sobc_rate_div #(
    .W (sobc_pkg::PRESCALE_CNT_W)
  ) u_prescale (
    .clk        (CLK),
    .rst_n      (RST_N),
    .clear      (div_clear),
    .en         (div_en),
    .div_minus1 (pre_div_m1),
    .tick       (pre_tick)
  );

  sobc_rate_div #(
    .W (sobc_pkg::RATE_CNT_W)
  ) u_rate (
    .clk        (CLK),
    .rst_n      (RST_N),
    .clear      (div_clear),
    .en         (pre_tick),
    .div_minus1 (rate_div_m1),
    .tick       (rate_tick)
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= rate_tick;
    end
  end

  assign BAUD_TICK = tick_reg;

  // Helper: configuration steady at the fastest rate
  logic fast_steady;
  assign fast_steady = (rate_reg == 8'h00) && run && MASTER_SELECT && !rate_wr;

  sequence fast_gap_s;
    !BAUD_TICK ##1 (BAUD_TICK || !$past(fast_steady));
  endsequence

  sequence len_change_s;
    opt_wr && MASTER_SELECT &&
      (opt_wdata[sobc_pkg::WORD_LEN_POS] != opt_reg.word_length_select);
  endsequence

  match_irq_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (RECEIVE_MATCH_FLAG && opt_reg.match_irq_enable) |=> MATCH_IRQ)
    else $error("match request missing");

  match_mask_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !opt_reg.match_irq_enable |=> !MATCH_IRQ)
    else $error("masked match request raised");

  length_abort_a: assert property (@(posedge CLK) disable iff (!RST_N)
    len_change_s |=> ABORT_IDLE ##1 (!ABORT_IDLE || $past(opt_wr)))
    else $error("length change did not abort once");

  slave_abort_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !MASTER_SELECT |=> !ABORT_IDLE)
    else $error("abort raised in slave mode");

  // Release edge skipped: the registers still load reset values there
  slave_select_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (RST_N && !MASTER_SELECT) |=> (PIN_DRIVE.ss_owned && !PIN_DRIVE.ss_oe && FAULT_IN_N
                        && SLAVE_SEL_N == $past(PIN_IN.ss_in)))
    else $error("slave select pin misrouted");

  ss_gpio_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (MASTER_SELECT && !opt_reg.fault_detect_enable) |=> !PIN_DRIVE.ss_owned && FAULT_IN_N)
    else $error("select pin not released");

  ss_output_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (MASTER_SELECT && opt_reg.fault_detect_enable) |=>
      PIN_DRIVE.ss_oe == $past(SELECT_OUTPUT_ENABLE))
    else $error("select output enable wrong");

  wire_oe_a: assert property (@(posedge CLK) disable iff (!RST_N)
    opt_reg.pin_layout_select |=> (MASTER_SELECT ? PIN_DRIVE.mosi_oe : PIN_DRIVE.miso_oe)
      == $past(opt_reg.single_wire_output_enable) || MASTER_SELECT != $past(MASTER_SELECT))
    else $error("shared pin direction wrong");

  normal_pins_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!opt_reg.pin_layout_select && MASTER_SELECT) |=> PIN_DRIVE.mosi_oe && !PIN_DRIVE.miso_oe
      && PIN_DRIVE.miso_owned)
    else $error("normal master pins wrong");

  unused_pin_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (opt_reg.pin_layout_select && !MASTER_SELECT) |=> !PIN_DRIVE.mosi_owned
      && !PIN_DRIVE.mosi_oe && SER_IN == $past(PIN_IN.miso_in))
    else $error("slave single-wire pins wrong");

  wait_stop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (opt_reg.wait_clock_stop && CPU_WAIT) |=> !BAUD_TICK)
    else $error("clocks run in wait");

  fast_rate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (BAUD_TICK && fast_steady) |=> fast_gap_s)
    else $error("fastest bit rate not two cycles");

  slave_rate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !MASTER_SELECT [*2] |=> !BAUD_TICK)
    else $error("baud tick in slave mode");

  reserved_bits_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (RD && ADDR == sobc_pkg::OPT_OFFSET) |=> RDATA[5] == 1'b0 && RDATA[2] == 1'b0)
    else $error("reserved option bit set");

endmodule : sobc_top

`default_nettype wire

// ===== common/sobc_pkg.sv
/*
  Shared constants and carrier types of the SPI option and baud control block.
  Assumes one bus clock and a simple strobe register port with 3-bit address.
*/
`default_nettype none

package sobc_pkg;

  // Register word offsets
  localparam logic [2:0] OPT_OFFSET  = 3'h0;
  localparam logic [2:0] RATE_OFFSET = 3'h1;

  // Option control field positions
  localparam int MATCH_IRQ_EN_POS = 7;
  localparam int WORD_LEN_POS     = 6;
  localparam int FAULT_EN_POS     = 4;
  localparam int WIRE_OE_POS      = 3;
  localparam int WAIT_STOP_POS    = 1;
  localparam int PIN_LAYOUT_POS   = 0;
  localparam logic [7:0] OPT_WRITE_MASK = 8'hdb;

  // Bit rate fields
  localparam int PRESCALE_LSB = 4;
  localparam int RATE_LSB     = 0;
  localparam int FIELD_W      = 3;
  localparam logic [7:0] RATE_WRITE_MASK = 8'h77;

  // Values after reset
  localparam logic [7:0] OPT_RESET  = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;

  // Divider counter widths
  localparam int PRESCALE_CNT_W = 3;
  localparam int RATE_CNT_W     = 8;

  typedef struct packed {
    logic match_irq_enable;
    logic word_length_select;
    logic rsv5;
    logic fault_detect_enable;
    logic single_wire_output_enable;
    logic rsv2;
    logic wait_clock_stop;
    logic pin_layout_select;
  } sobc_opt_t;

  // Pin drive toward the pad ring
  typedef struct packed {
    logic mosi_out;
    logic mosi_oe;
    logic mosi_owned;
    logic miso_out;
    logic miso_oe;
    logic miso_owned;
    logic ss_out;
    logic ss_oe;
    logic ss_owned;
  } sobc_pins_t;

  // Pin levels from the pad ring
  typedef struct packed {
    logic mosi_in;
    logic miso_in;
    logic ss_in;
  } sobc_pin_in_t;

endpackage : sobc_pkg

`default_nettype wire

// ===== hdl/sobc_rate_div.sv
/*
  Enable-driven modulo counter: one tick per (div_minus1 + 1) enables.
  Assumes div_minus1 is steady or that clear is pulsed when it changes.
*/
`default_nettype none

module sobc_rate_div #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         en,
  input  wire logic [W-1:0] div_minus1,
  output logic              tick
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Compare with >= so a lowered divisor cannot strand the count
  assign tick = en && (cnt_reg >= div_minus1);

  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (tick) begin
      cnt_next = '0;
    end else if (en) begin
      cnt_next = W'(cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : sobc_rate_div

`default_nettype wire

// ===== tb/sobc_pad_model.sv
/*
  Far side SPI device on the pads: drives the lines that it is told to drive.
  Assumes the bench says which lines the far device drives and at what level.
*/
`default_nettype none

module sobc_pad_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire sobc_pkg::sobc_pins_t   drive,
  input  wire logic [2:0]             far_oe,
  input  wire logic [2:0]             far_val,
  output sobc_pkg::sobc_pin_in_t      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] float_reg;

  // Undriven lines toggle so a stale level never passes for data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) float_reg <= 3'h5;
    else float_reg <= ~float_reg;
  end

  always_comb begin
    pin_in.mosi_in = drive.mosi_oe ? drive.mosi_out : (far_oe[2] ? far_val[2] : float_reg[2]);
    pin_in.miso_in = drive.miso_oe ? drive.miso_out : (far_oe[1] ? far_val[1] : float_reg[1]);
    pin_in.ss_in   = drive.ss_oe ? drive.ss_out : (far_oe[0] ? far_val[0] : float_reg[0]);
  end
endmodule // sobc_pad_model

`default_nettype wire

// ===== tb/sobc_top_tb.sv
/*
  Self-checking bench of the SPI option and baud control block.
  Assumes the pad model stands on the pins as the far device.
*/
`default_nettype none

module sobc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;
  logic                   rst_n, wr, rd, mst, select_output_enable, mflag, cwait, sout, seldn;
  logic [2:0]             addr, foe, fval;
  logic [7:0]             wdata, rdata;
  logic                   sin, ssn, fltn, irq, w16, abrt, crun, tick;
  sobc_pkg::sobc_pins_t   pins;
  sobc_pkg::sobc_pin_in_t pin_in;
  int                     mismatches = 0;
  int                     comparisons = 0;
  int                     cycles = 0;

  sobc_top u_sobc_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MASTER_SELECT(mst), .SELECT_OUTPUT_ENABLE(select_output_enable), .RECEIVE_MATCH_FLAG(mflag),
    .CPU_WAIT(cwait), .SER_OUT(sout), .SEL_DRIVE_N(seldn), .PIN_IN(pin_in), .PIN_DRIVE(pins),
    .SER_IN(sin), .SLAVE_SEL_N(ssn), .FAULT_IN_N(fltn), .MATCH_IRQ(irq), .WORD_16(w16),
    .ABORT_IDLE(abrt), .CLK_RUN(crun), .BAUD_TICK(tick));

  sobc_pad_model u_sobc_pad_model (.clk(clk), .rst_n(rst_n), .drive(pins), .far_oe(foe),
    .far_val(fval), .pin_in(pin_in));

  always #12.5 clk = ~clk;

  // Whole run needs about 5700 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h0, rdata}, {8'h0, e});
  endtask

  task automatic ticks(input int n, output logic [15:0] k);
    k = 16'h0;
    repeat (n) begin
      @(posedge clk);
      #1;
      k += tick;
    end
  endtask

  // Cycles up to the next tick; bounded so a dead divider cannot hang
  task automatic gap(output logic [15:0] k);
    k = 16'h0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (tick !== 1'b1 && k < 16'h1400);
  endtask

  task automatic t_regs();
    rd_chk(sobc_pkg::OPT_OFFSET, 8'h00);
    rd_chk(sobc_pkg::RATE_OFFSET, 8'h00);
    wr_reg(sobc_pkg::OPT_OFFSET, 8'hff);
    rd_chk(sobc_pkg::OPT_OFFSET, 8'hdb);
    step(1);
    chk({8'h0, rdata}, 16'h0000);
    wr_reg(sobc_pkg::RATE_OFFSET, 8'hff);
    wr_reg(3'h5, 8'h3c);
    rd_chk(sobc_pkg::RATE_OFFSET, 8'h77);
    rd_chk(3'h5, 8'h00);
    rd_chk(sobc_pkg::OPT_OFFSET, 8'hdb);
    wr_reg(sobc_pkg::OPT_OFFSET, 8'h00);
    $display("test regs done");
  endtask

  task automatic irq_case(input logic en, input logic fl);
    @(posedge clk);
    mflag <= fl;
    wr_reg(sobc_pkg::OPT_OFFSET, {en, 7'h0});
    step(2);
    chk({15'h0, irq}, {15'h0, en & fl});
  endtask

  task automatic len_case(input logic m, input logic [7:0] d, input logic [15:0] e);
    logic [15:0] n;
    @(posedge clk);
    mst <= m;
    wr_reg(sobc_pkg::OPT_OFFSET, d);
    n = 16'h0;
    repeat (3) begin
      #1;
      n += abrt;
      @(posedge clk);
    end
    chk(n, e);
    chk({15'h0, w16}, {15'h0, d[6]});
  endtask

  task automatic t_pins();
    logic m, l, w, emo, emi, smo;
    for (int i = 0; i < 16; i++) begin
      {m, l, w} = i[3:1];
      emo = m ? (l ? w : 1'b1) : 1'b0;
      emi = m ? 1'b0 : (l ? w : 1'b1);
      smo = m ? l : ~l;
      @(posedge clk);
      mst <= m;
      sout <= i[0];
      // Far side drives the inverse so a wrong pin choice shows
      fval <= i[0] ? 3'h0 : 3'h6;
      foe <= {~emo, ~emi, 1'b1};
      wr_reg(sobc_pkg::OPT_OFFSET, {4'h0, w, 2'h0, l});
      step(3);
      chk({12'h0, pins.mosi_oe, pins.mosi_owned, pins.miso_oe, pins.miso_owned},
          {12'h0, emo, m | ~l, emi, ~m | ~l});
      chk({13'h0, pins.mosi_oe & pins.mosi_out, pins.miso_oe & pins.miso_out, sin},
          {13'h0, emo & i[0], emi & i[0], (smo ? emo : emi) ? i[0] : ~i[0]});
    end
    $display("test pins done");
  endtask

  task automatic t_ss();
    logic m, f, s, d;
    for (int i = 0; i < 16; i++) begin
      {m, f, s, d} = i[3:0];
      @(posedge clk);
      mst <= m;
      select_output_enable <= s;
      seldn <= d;
      foe <= {2'h0, ~(m & f & s)};
      fval <= {2'h0, ~d};
      wr_reg(sobc_pkg::OPT_OFFSET, {3'h0, f, 4'h0});
      step(3);
      chk({11'h0, pins.ss_oe, pins.ss_owned, pins.ss_oe & pins.ss_out, ssn, fltn},
          {11'h0, m & f & s, ~m | f, m & f & s & d, m | ~d, ~(m & f & ~s & d)});
    end
    $display("test select done");
  endtask

  task automatic t_baud();
    logic [7:0]  c [5] = '{8'h00, 8'h70, 8'h07, 8'h23, 8'h77};
    logic [15:0] k;
    @(posedge clk);
    mst <= 1'b1;
    foreach (c[j]) begin
      wr_reg(sobc_pkg::RATE_OFFSET, c[j]);
      gap(k);
      gap(k);
      chk(k, ({13'h0, c[j][6:4]} + 16'h1) << ({1'b0, c[j][2:0]} + 4'h1));
    end
    @(posedge clk);
    mst <= 1'b0;
    step(4);
    ticks(600, k);
    chk(k, 16'h0);
    $display("test baud done");
  endtask

  task automatic wait_case(input logic [7:0] opt, input logic cw, input logic [15:0] e);
    logic [15:0] k;
    wr_reg(sobc_pkg::OPT_OFFSET, opt);
    @(posedge clk);
    cwait <= cw;
    step(1);
    chk({15'h0, crun}, {15'h0, ~(opt[1] & cw)});
    step(3);
    ticks(20, k);
    chk(k, e);
  endtask

  initial begin
    rst_n = 1'b0;
    {wr, rd, mst, select_output_enable, mflag, cwait, sout, seldn} = 8'h01;
    {addr, foe, fval, wdata} = 17'h0;
    step(15);
    chk({6'h0, sin, pins}, 16'h0000);
    chk({1'b0, crun, w16, ssn, fltn, irq, abrt, tick, rdata}, 16'h5800);
    @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    irq_case(1'b1, 1'b1);
    irq_case(1'b1, 1'b0);
    irq_case(1'b0, 1'b1);
    irq_case(1'b1, 1'b1);
    $display("test irq done");
    len_case(1'b1, 8'h40, 16'h1);
    len_case(1'b1, 8'h40, 16'h0);
    len_case(1'b1, 8'h00, 16'h1);
    len_case(1'b0, 8'h40, 16'h0);
    len_case(1'b0, 8'h00, 16'h0);
    $display("test length done");
    t_pins();
    t_ss();
    t_baud();
    @(posedge clk);
    mst <= 1'b1;
    wr_reg(sobc_pkg::RATE_OFFSET, 8'h00);
    wait_case(8'h02, 1'b1, 16'h0);
    wait_case(8'h02, 1'b0, 16'ha);
    wait_case(8'h00, 1'b1, 16'ha);
    $display("test wait done");
    end_of_test();
  end
endmodule // sobc_top_tb

`default_nettype wire
